// [core/swfsm_pkg.sv]
// swfsm_pkg: constants, states and carriers of the strobed receiver wake-up state machine.
// assumes a 25 MHz system clock; all other timing is derived here.
package swfsm_pkg;
    localparam int          SYS_CLK_HZ       = 25000000;
    localparam int          SAMPLE_CLK_HZ    = 615000;
    // sampling period in cycles, rounded down (1.6 us nominal)
    localparam int          SAMPLE_DIV       = SYS_CLK_HZ / SAMPLE_CLK_HZ;
    localparam int          ID_BAUD_HZ       = 310000;
    localparam int          ID_BIT_DIV       = SYS_CLK_HZ / ID_BAUD_HZ;
    localparam int          HDR_TIMEOUT      = 66;
    localparam int          HDR_TIMEOUT_TOL  = 1;
    localparam logic [7:0]  HDR_TIMEOUT_MAX  = 8'(HDR_TIMEOUT + HDR_TIMEOUT_TOL);
    localparam logic [7:0]  STROBE_RUN_PER   = 8'h01;
    localparam logic [2:0]  BIT_LAST         = 3'h7;
    localparam logic [1:0]  SLEEP_ENTRY_TS   = 2'h2;
    localparam logic [7:0]  DUMMY_BYTE       = 8'h00;
    localparam int          FIFO_WIDTH       = 9;
    localparam int          FIFO_DEPTH       = 32;

    typedef enum logic [3:0] {
        SWFSM_CONFIG,
        SWFSM_OSC_SLEEP,
        SWFSM_OSC_LISTEN,
        SWFSM_OSC_HDR_WAIT,
        SWFSM_OSC_DATA,
        SWFSM_PIN_SLEEP,
        SWFSM_PIN_LISTEN,
        SWFSM_PIN_ID_SEND,
        SWFSM_PIN_HDR_WAIT,
        SWFSM_PIN_DATA,
        SWFSM_PIN_RAW,
        SWFSM_TO_SLEEP
    } swfsm_state_e;

    // decoder events from the demodulator, one-cycle pulses
    typedef struct packed {
        logic match_word;
        logic match_word_inv;
        logic header;
        logic header_inv;
        logic end_of_msg;
        logic strobe_tick;
    } swfsm_event_s;

    // data byte with end-of-message marker as it enters the fifo
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } swfsm_word_s;

    // serial lines toward the host, plus the power-up and oscillator discharge controls
    typedef struct packed {
        logic sdata;
        logic sclk;
        logic sclk_oe;
        logic power_up;
        logic osc_discharge_en;
    } swfsm_link_s;
endpackage : swfsm_pkg

// [core/swfsm_fifo.sv]
// swfsm_fifo: flip-flop fifo of parameter width and depth, valid/ready on both sides.
// assumes one clock and a synchronised active-low reset copy, applied asynchronously here.
`timescale 1ns/1ps
module swfsm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } swfsm_fifo_s;

    swfsm_fifo_s st, next_st;
    logic push, pop;

    assign in_ready_o  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o  = st.mem[st.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_i;
            next_st.wr         = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : swfsm_fifo

// [core/swfsm_top.sv]
// swfsm_top: wake-up and run control state machine of a strobed uhf data receiver.
// assumes decoder events and bytes arrive synchronous to sys_clk_i; the host spi is a slave.
`timescale 1ns/1ps
module swfsm_top
    import swfsm_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         config_hold_n_i,
    input  wire logic         wake_osc_enable_i,
    input  wire logic         packet_handler_enable_i,
    input  wire logic         wake_pin_i,
    input  wire logic         wake_pin_at_supply_i,
    input  wire logic [7:0]   match_word_i,
    input  wire logic         raw_data_i,
    input  wire swfsm_event_s event_i,
    input  wire logic         byte_valid_i,
    input  wire logic [7:0]   byte_data_i,
    output logic              byte_ready_o,
    output swfsm_link_s       link_o,
    output swfsm_state_e      state_o
);
    typedef struct packed {
        swfsm_state_e state;
        swfsm_state_e target;
        logic [5:0]   samp_cnt;
        logic         samp_tick;
        logic         hold_seen;
        logic [7:0]   timeout;
        logic         strobe_end;
        logic         invert;
        logic         pending;
        logic [1:0]   delay;
        logic         drain;
        logic [7:0]   sreg;
        logic [3:0]   bits;
        logic [5:0]   bit_cnt;
        logic         bit_half;
        logic         ev_word;
        logic         ev_hdr;
        logic         ev_hdr_inv;
        logic         ev_eom;
        swfsm_link_s  link;
    } swfsm_top_s;

    logic          rst_meta;
    logic          rst_sync;
    swfsm_top_s    st, next_st;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    swfsm_word_s   fifo_out;
    swfsm_word_s   fifo_in;
    logic          data_state;
    logic          shifting;
    logic          bit_step;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign data_state = (st.state == SWFSM_OSC_DATA) || (st.state == SWFSM_PIN_DATA);
    assign fifo_in    = '{last: event_i.end_of_msg, data: byte_data_i};
    assign shifting   = (st.bits != '0);
    assign fifo_out_ready = data_state && !shifting && packet_handler_enable_i;
    // bit rate: 310 kBd for the match byte, sample-rate halves for data
    // each bit is two steps, so the match byte steps at half its bit time
    assign bit_step   = (st.state == SWFSM_PIN_ID_SEND) ? (st.bit_cnt == 6'(ID_BIT_DIV / 2 - 1))
                                                        : st.samp_tick;

    // bytes queue here so a slow shift-out stalls the decoder instead of losing data
    swfsm_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (sys_clk_i),
        .rst_n_i     (rst_sync),
        .in_valid_i  (byte_valid_i && data_state),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out)
    );

    always_comb begin
        next_st = st;
        next_st.samp_tick = 1'b0;
        // sample period divider
        if (st.samp_cnt == 6'(SAMPLE_DIV - 1)) begin
            next_st.samp_cnt  = '0;
            next_st.samp_tick = 1'b1;
        end else begin
            next_st.samp_cnt = st.samp_cnt + 1'b1;
        end
        // events are latched and acted on at the next sample tick
        next_st.ev_word    = st.ev_word | event_i.match_word | event_i.match_word_inv;
        next_st.ev_hdr     = st.ev_hdr | event_i.header;
        next_st.ev_hdr_inv = st.ev_hdr_inv | event_i.header_inv;
        next_st.ev_eom     = st.ev_eom | (event_i.end_of_msg & byte_valid_i);
        if (event_i.strobe_tick) begin
            next_st.strobe_end = 1'b1;
        end
        if (event_i.strobe_tick && st.state == SWFSM_OSC_HDR_WAIT) begin
            next_st.timeout = st.timeout + 1'b1;
        end
        // serial shifter, msb first, clock high in second half of bit in the data states only
        if (shifting && bit_step) begin
            if (!st.bit_half) begin
                next_st.bit_half = 1'b1;
                next_st.link.sclk = packet_handler_enable_i && data_state;
            end else begin
                next_st.bit_half  = 1'b0;
                next_st.link.sclk = 1'b0;
                next_st.bits      = st.bits - 1'b1;
                next_st.sreg      = {st.sreg[6:0], 1'b0};
                next_st.link.sdata = st.sreg[6] ^ (st.invert & data_state);
            end
        end
        next_st.bit_cnt = (shifting && !bit_step) ? st.bit_cnt + 1'b1 : '0;
        if (fifo_out_ready && fifo_out_valid) begin
            next_st.sreg       = fifo_out.data;
            next_st.bits       = 4'(BIT_LAST) + 4'h1;
            next_st.link.sdata = fifo_out.data[7] ^ st.invert;
        end
        if (st.state == SWFSM_PIN_RAW) begin
            next_st.link.sdata = raw_data_i;
            next_st.link.sclk  = 1'b0;
        end
        next_st.link.sclk_oe = packet_handler_enable_i && config_hold_n_i;
        next_st.link.osc_discharge_en = wake_osc_enable_i && !wake_pin_at_supply_i;
        next_st.link.power_up = !(st.state == SWFSM_OSC_SLEEP
                                  || st.state == SWFSM_PIN_SLEEP);

        if (st.samp_tick) begin
            next_st.hold_seen = !config_hold_n_i;
            case (st.state)
                SWFSM_CONFIG: begin
                    if (config_hold_n_i) begin
                        next_st.state = wake_osc_enable_i ? SWFSM_OSC_SLEEP : SWFSM_PIN_SLEEP;
                    end
                end
                SWFSM_OSC_SLEEP: begin
                    if (!wake_osc_enable_i) begin
                        next_st.state = SWFSM_PIN_SLEEP;
                    end else if (st.strobe_end || wake_pin_i) begin
                        next_st.state      = SWFSM_OSC_LISTEN;
                        next_st.strobe_end = 1'b0;
                        next_st.ev_word    = 1'b0;
                    end
                end
                SWFSM_OSC_LISTEN: begin
                    if (st.ev_word) begin
                        next_st.state   = SWFSM_OSC_HDR_WAIT;
                        next_st.timeout = '0;
                        next_st.ev_hdr  = 1'b0;
                        next_st.ev_hdr_inv = 1'b0;
                    end else if (st.strobe_end && !wake_pin_i && !wake_pin_at_supply_i) begin
                        next_st.target  = SWFSM_OSC_SLEEP;
                        next_st.state   = SWFSM_TO_SLEEP;
                        next_st.delay   = SLEEP_ENTRY_TS - 2'h1;
                    end else if (st.strobe_end) begin
                        next_st.strobe_end = 1'b0;
                    end
                end
                SWFSM_OSC_HDR_WAIT: begin
                    if (st.ev_hdr || st.ev_hdr_inv) begin
                        next_st.state  = SWFSM_OSC_DATA;
                        next_st.invert = st.ev_hdr_inv;
                        next_st.ev_eom = 1'b0;
                    end else if (st.timeout >= HDR_TIMEOUT_MAX - 8'h1) begin
                        next_st.target = SWFSM_OSC_SLEEP;
                        next_st.state  = SWFSM_TO_SLEEP;
                        next_st.delay  = SLEEP_ENTRY_TS - 2'h1;
                    end
                end
                SWFSM_OSC_DATA: begin
                    if (st.ev_eom && !fifo_out_valid && !shifting) begin
                        // dummy byte shifts with sclk held low, holding off sleep for one byte time
                        next_st.sreg   = DUMMY_BYTE;
                        next_st.bits   = 4'(BIT_LAST) + 4'h1;
                        next_st.drain  = 1'b1;
                        next_st.target = SWFSM_OSC_SLEEP;
                        next_st.state  = SWFSM_TO_SLEEP;
                        next_st.delay  = SLEEP_ENTRY_TS - 2'h1;
                    end
                end
                SWFSM_PIN_SLEEP: begin
                    if (wake_osc_enable_i) begin
                        next_st.state = SWFSM_OSC_SLEEP;
                    end else if (wake_pin_i || wake_pin_at_supply_i) begin
                        next_st.state   = SWFSM_PIN_LISTEN;
                        next_st.ev_word = 1'b0;
                    end
                end
                SWFSM_PIN_LISTEN: begin
                    if (!wake_pin_i && !wake_pin_at_supply_i) begin
                        next_st.target = SWFSM_PIN_SLEEP;
                        next_st.state  = SWFSM_TO_SLEEP;
                        next_st.delay  = SLEEP_ENTRY_TS - 2'h1;
                    end else if (st.ev_word) begin
                        next_st.state  = SWFSM_PIN_ID_SEND;
                        next_st.sreg   = match_word_i;
                        next_st.bits   = 4'(BIT_LAST) + 4'h1;
                        next_st.link.sdata = match_word_i[7];
                    end
                end
                SWFSM_PIN_ID_SEND: begin
                    if (!wake_pin_i) begin
                        next_st.target = SWFSM_PIN_SLEEP;
                        next_st.state  = SWFSM_TO_SLEEP;
                        next_st.delay  = SLEEP_ENTRY_TS - 2'h1;
                        next_st.bits   = '0;
                    end else if (!shifting) begin
                        next_st.state  = SWFSM_PIN_HDR_WAIT;
                        next_st.ev_hdr = 1'b0;
                        next_st.ev_hdr_inv = 1'b0;
                    end
                end
                SWFSM_PIN_HDR_WAIT: begin
                    if (!wake_pin_i) begin
                        next_st.target = SWFSM_PIN_SLEEP;
                        next_st.state  = SWFSM_TO_SLEEP;
                        next_st.delay  = SLEEP_ENTRY_TS - 2'h1;
                    end else if (st.ev_hdr || st.ev_hdr_inv) begin
                        next_st.state  = SWFSM_PIN_DATA;
                        next_st.invert = st.ev_hdr_inv;
                        next_st.ev_eom = 1'b0;
                    end
                end
                SWFSM_PIN_DATA: begin
                    if (!wake_pin_i) begin
                        // current byte keeps shifting during the sleep entry
                        next_st.drain  = shifting;
                        next_st.target = SWFSM_PIN_SLEEP;
                        next_st.state  = SWFSM_TO_SLEEP;
                        next_st.delay  = SLEEP_ENTRY_TS - 2'h1;
                    end else if (st.ev_eom && !fifo_out_valid && !shifting) begin
                        next_st.state = SWFSM_PIN_RAW;
                    end
                end
                SWFSM_PIN_RAW: begin
                    if (!wake_pin_i) begin
                        next_st.target = SWFSM_PIN_SLEEP;
                        next_st.state  = SWFSM_TO_SLEEP;
                        next_st.delay  = SLEEP_ENTRY_TS - 2'h1;
                    end
                end
                SWFSM_TO_SLEEP: begin
                    // two sample periods of sleep entry, stretched while a byte drains
                    if (st.delay != '0) begin
                        next_st.delay = st.delay - 2'h1;
                    end else if (!(st.drain && shifting)) begin
                        next_st.state  = st.target;
                        next_st.drain  = 1'b0;
                        next_st.invert = 1'b0;
                        next_st.strobe_end = 1'b0;
                    end
                end
                default: begin
                    next_st.state = SWFSM_CONFIG;
                end
            endcase
            // hold low over two consecutive ticks means longer than one period
            if (!config_hold_n_i && st.hold_seen) begin
                next_st.state = SWFSM_CONFIG;
                next_st.bits  = '0;
                next_st.drain = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync) begin
        if (!rst_sync) begin
            st          <= '0;
            st.state    <= SWFSM_CONFIG;
            st.target   <= SWFSM_CONFIG;
            byte_ready_o <= 1'b0;
            link_o      <= '0;
            state_o     <= SWFSM_CONFIG;
        end else begin
            st          <= next_st;
            byte_ready_o <= fifo_in_ready;
            link_o      <= next_st.link;
            state_o     <= next_st.state;
        end
    end
endmodule : swfsm_top

// [sim/swfsm_asserts.sv]
// swfsm_asserts: port checks of swfsm_top, bound after the module.
// assumes one clock; counters carry the windows too long for repetition.
`timescale 1ns/1ps
module swfsm_asserts
    import swfsm_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         config_hold_n_i,
    input  wire logic         wake_osc_enable_i,
    input  wire logic         wake_pin_i,
    input  wire logic         wake_pin_at_supply_i,
    input  wire swfsm_event_s event_i,
    input  wire swfsm_link_s  link_o,
    input  wire swfsm_state_e state_o
);
    logic [6:0] hold_cnt;
    logic [7:0] hdr_ticks;
    logic [5:0] sup_cnt;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_cnt  <= 7'h00;
            hdr_ticks <= 8'h00;
            sup_cnt   <= 6'h00;
        end else begin
            hold_cnt  <= config_hold_n_i ? 7'h00 : hold_cnt + 7'(hold_cnt != 7'h7F);
            hdr_ticks <= (state_o != SWFSM_OSC_HDR_WAIT) ? 8'h00
                         : hdr_ticks + 8'(event_i.strobe_tick);
            sup_cnt   <= !wake_pin_at_supply_i ? 6'h00 : sup_cnt + 6'(sup_cnt != 6'h3F);
        end
    end
    sequence s_sleep_arrive;
        $past(state_o) == SWFSM_TO_SLEEP ##0 state_o inside {SWFSM_OSC_SLEEP, SWFSM_PIN_SLEEP};
    endsequence
    sequence s_pin_low;
        state_o inside {SWFSM_PIN_ID_SEND, SWFSM_PIN_HDR_WAIT} ##0 (!wake_pin_i && config_hold_n_i);
    endsequence
    property p_sleep_off;
        state_o == SWFSM_OSC_SLEEP && $past(state_o) == SWFSM_OSC_SLEEP |-> !link_o.power_up;
    endproperty
    property p_hold_cfg;
        hold_cnt >= 7'd90 |-> state_o == SWFSM_CONFIG;
    endproperty
    property p_sleep_entry;
        s_sleep_arrive |-> $past(state_o, 60) == SWFSM_TO_SLEEP;
    endproperty
    property p_osc_match;
        state_o == SWFSM_OSC_LISTEN && (event_i.match_word || event_i.match_word_inv)
            && config_hold_n_i |-> ##[1:42] state_o == SWFSM_OSC_HDR_WAIT;
    endproperty
    property p_hdr_late;
        state_o == SWFSM_OSC_HDR_WAIT |-> hdr_ticks <= 8'd67;
    endproperty
    property p_pin_drop;
        s_pin_low |-> ##[1:42] state_o == SWFSM_TO_SLEEP;
    endproperty
    property p_listen_stay;
        state_o == SWFSM_PIN_LISTEN && wake_pin_i && config_hold_n_i && !wake_osc_enable_i
            |=> state_o inside {SWFSM_PIN_LISTEN, SWFSM_PIN_ID_SEND};
    endproperty
    property p_supply;
        sup_cnt >= 6'd50 |-> !link_o.osc_discharge_en;
    endproperty
    property p_raw_noclk;
        state_o == SWFSM_PIN_RAW && $past(state_o) == SWFSM_PIN_RAW |-> $stable(link_o.sclk);
    endproperty
    a_sleep_off:   assert property (p_sleep_off) else $error("power up in strobed sleep");
    a_hold_cfg:    assert property (p_hold_cfg) else $error("hold low without config");
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry too short");
    a_osc_match:   assert property (p_osc_match) else $error("match not taken");
    a_hdr_late:    assert property (p_hdr_late) else $error("header wait overran");
    a_pin_drop:    assert property (p_pin_drop) else $error("pin low ignored");
    a_listen_stay: assert property (p_listen_stay) else $error("listen left early");
    a_supply:      assert property (p_supply) else $error("discharge on at supply");
    a_raw_noclk:   assert property (p_raw_noclk) else $error("clock in raw output");
endmodule : swfsm_asserts

bind swfsm_top swfsm_asserts u_asserts (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .config_hold_n_i(config_hold_n_i),
    .wake_osc_enable_i(wake_osc_enable_i), .wake_pin_i(wake_pin_i),
    .wake_pin_at_supply_i(wake_pin_at_supply_i), .event_i(event_i), .link_o(link_o),
    .state_o(state_o)
);

// [sim/swfsm_host_model.sv]
// swfsm_host_model: host microcontroller, spi port as slave, owner of the wake pin.
// assumes sclk means nothing while its enable is low; bit count restarts then.
`timescale 1ns/1ps
module swfsm_host_model (
    input  wire logic       clk_i,
    input  wire logic       sclk_i,
    input  wire logic       sclk_oe_i,
    input  wire logic       sdata_i,
    input  wire logic       keep_awake_i,
    output logic            wake_pin_o,
    output logic      [7:0] rx_byte_o,
    output logic      [7:0] rx_count_o
);
    logic       sclk_q = 1'b0;
    logic [2:0] bit_cnt = 3'h0;
    logic [7:0] shift = 8'h00;
    // pin stays high while message data are wanted
    assign wake_pin_o = keep_awake_i;
    initial rx_count_o = 8'h00;
    initial rx_byte_o = 8'h00;
    always @(posedge clk_i) begin
        sclk_q <= sclk_i;
        if (!sclk_oe_i) begin
            bit_cnt <= 3'h0;
        end else if (sclk_i && !sclk_q) begin
            shift   <= {shift[6:0], sdata_i};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                rx_byte_o  <= {shift[6:0], sdata_i};
                rx_count_o <= rx_count_o + 8'h01;
            end
        end
    end
endmodule : swfsm_host_model

// [sim/swfsm_top_tb.sv]
// swfsm_top_tb: directed scenarios for swfsm_top with a host model on the serial side.
// assumes the 40-cycle sample tick and 80-cycle id bit of the package.
`timescale 1ns/1ps
module swfsm_top_tb
    import swfsm_pkg::*;
;
    logic         sys_clk, rst_n = 1'b0, hold_n = 1'b0, osc_en = 1'b1, ph_en = 1'b1;
    logic         at_supply = 1'b0, raw_data = 1'b0, byte_valid = 1'b0, keep = 1'b0;
    logic [7:0]   byte_data = 8'h00;
    logic [5:0]   event_r = 6'h00;
    wire          wake_pin, byte_ready;
    wire [7:0]    rx_byte, rx_count;
    swfsm_link_s  link;
    swfsm_state_e state;
    int           fails = 0, tests_run = 0;
    localparam logic [7:0] MATCH = 8'hB4;

    swfsm_top uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .config_hold_n_i(hold_n),
        .wake_osc_enable_i(osc_en), .packet_handler_enable_i(ph_en), .wake_pin_i(wake_pin),
        .wake_pin_at_supply_i(at_supply), .match_word_i(MATCH), .raw_data_i(raw_data),
        .event_i(swfsm_event_s'(event_r)), .byte_valid_i(byte_valid), .byte_data_i(byte_data),
        .byte_ready_o(byte_ready), .link_o(link), .state_o(state));
    swfsm_host_model host (.clk_i(sys_clk), .sclk_i(link.sclk), .sclk_oe_i(link.sclk_oe),
        .sdata_i(link.sdata), .keep_awake_i(keep), .wake_pin_o(wake_pin),
        .rx_byte_o(rx_byte), .rx_count_o(rx_count));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic ev(input logic [5:0] e);
        @(posedge sys_clk);
        event_r <= e;
        @(posedge sys_clk);
        event_r <= 6'h00;
    endtask : ev
    task automatic wait_st(input swfsm_state_e s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        check(state, s);
    endtask : wait_st
    // strobe ticks spaced wider than the sample tick so none merge
    task automatic ticks(input int k);
        repeat (k) begin
            ev(6'h01);
            repeat (48) @(posedge sys_clk);
        end
    endtask : ticks
    // offer one byte, wait for acceptance, then the host's next whole byte
    task automatic send_byte(input logic [7:0] b, input logic [7:0] exp);
        int n;
        logic [7:0] c;
        n = 0;
        c = rx_count;
        @(posedge sys_clk);
        byte_valid <= 1'b1;
        byte_data <= b;
        event_r <= 6'h02;
        do begin
            @(posedge sys_clk);
            n++;
        end while (byte_ready !== 1'b1 && n < 200);
        byte_valid <= 1'b0;
        event_r <= 6'h00;
        while (rx_count === c && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        check(rx_byte, exp);
    endtask : send_byte
    task automatic t_reset;
        repeat (10) @(posedge sys_clk);
        check(state, SWFSM_CONFIG);
        check(link, 5'h00);
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        hold_n <= 1'b1;
        wait_st(SWFSM_OSC_SLEEP, 200);
        repeat (50) @(posedge sys_clk);
        check(link.power_up, 1'b0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_osc_timeout;
        ticks(1);
        wait_st(SWFSM_OSC_LISTEN, 100);
        ticks(1);
        wait_st(SWFSM_OSC_SLEEP, 200);
        ticks(1);
        wait_st(SWFSM_OSC_LISTEN, 100);
        ev(6'h10);
        wait_st(SWFSM_OSC_HDR_WAIT, 60);
        ticks(65);
        check(state, SWFSM_OSC_HDR_WAIT);
        ticks(3);
        wait_st(SWFSM_OSC_SLEEP, 200);
        $display("t_osc_timeout done");
    endtask : t_osc_timeout
    task automatic t_osc_data;
        ticks(1);
        wait_st(SWFSM_OSC_LISTEN, 100);
        ev(6'h20);
        wait_st(SWFSM_OSC_HDR_WAIT, 60);
        ev(6'h08);
        wait_st(SWFSM_OSC_DATA, 60);
        send_byte(8'h3C, 8'h3C);
        wait_st(SWFSM_OSC_SLEEP, 3000);
        $display("t_osc_data done");
    endtask : t_osc_data
    task automatic t_pin;
        logic [7:0] id;
        check(link.osc_discharge_en, 1'b1);
        at_supply <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check(link.osc_discharge_en, 1'b0);
        osc_en <= 1'b0;
        wait_st(SWFSM_PIN_SLEEP, 200);
        keep <= 1'b1;
        at_supply <= 1'b1;
        wait_st(SWFSM_PIN_LISTEN, 100);
        repeat (100) @(posedge sys_clk);
        check(link.osc_discharge_en, 1'b0);
        at_supply <= 1'b0;
        ev(6'h20);
        wait_st(SWFSM_PIN_ID_SEND, 60);
        repeat (40) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            id = {id[6:0], link.sdata};
            repeat (80) @(posedge sys_clk);
        end
        check(id, MATCH);
        wait_st(SWFSM_PIN_HDR_WAIT, 200);
        ev(6'h04);
        wait_st(SWFSM_PIN_DATA, 60);
        send_byte(8'hA5, 8'h5A);
        wait_st(SWFSM_PIN_RAW, 2000);
        keep <= 1'b0;
        wait_st(SWFSM_PIN_SLEEP, 200);
        $display("t_pin done");
    endtask : t_pin
    task automatic t_pin_drop_hold;
        keep <= 1'b1;
        wait_st(SWFSM_PIN_LISTEN, 100);
        ev(6'h20);
        wait_st(SWFSM_PIN_HDR_WAIT, 1000);
        keep <= 1'b0;
        wait_st(SWFSM_PIN_SLEEP, 200);
        hold_n <= 1'b0;
        repeat (100) @(posedge sys_clk);
        check(state, SWFSM_CONFIG);
        hold_n <= 1'b1;
        wait_st(SWFSM_PIN_SLEEP, 200);
        $display("t_pin_drop_hold done");
    endtask : t_pin_drop_hold
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #2400000;
        fails++;
        finish_test();
    end
    initial begin
        t_reset();
        t_osc_timeout();
        t_osc_data();
        t_pin();
        t_pin_drop_hold();
        finish_test();
    end
endmodule : swfsm_top_tb
